// ===== hw/dbgp_top.sv
// dual bidirectional gpio ports behind an axi4-lite slave
//
// Contract
// - eight-pin port with one data bit and one direction bit per pin.
// - direction bit 1 turns the pin driver off, pin is input.
// - direction bit 0 drives the pin from the output latch.
// - data register reads return synchronised pin levels, not the latch.
// - data writes are read-modify-write of sampled pins into the latch.
// - pins selected as analog inputs read as zero.
// - four-pin port with the same input-when-set direction rule.
// - top pin of four-pin port is input only, direction reads 1.
// - input-only top pin reads zero while master clear is enabled.
// - all eight wide direction bits reset to one.
// - data latch is undefined after power-up and kept otherwise.
// - unimplemented bits read zero and ignore writes.
// - lower five wide pins are plain gpio only.
// - upper three wide pins can be pwm outputs overriding the latch.
// - lower three narrow pins can be gpio or analog inputs.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`include "dbgp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dbgp_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] wide_pin_in,
    output logic [7:0] wide_pin_out,
    output logic [7:0] wide_pin_oe_n,
    input wire logic [2:0] narrow_pin_in,
    input wire logic input_only_top_pin,
    output logic [2:0] narrow_pin_out,
    output logic [2:0] narrow_pin_oe_n,
    input wire logic pwm_channel_b_out,
    input wire logic pwm_channel_c_out,
    input wire logic pwm_channel_d_out
);

    dbgp_pkg::dbgp_state_s s_reg;
    dbgp_pkg::dbgp_state_s s_next;

    logic [7:0] wide_rd;
    logic [3:0] nar_rd;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_lane0;

    // ------------------------------------------------------------------------
    // read values of the ports
    // ------------------------------------------------------------------------
    always_comb begin
        wide_rd = s_reg.wide_sync2;
        nar_rd[2:0] = s_reg.nar_sync2[2:0] & ~s_reg.analog_sel;
        nar_rd[`DBGP_TOP_PIN_BIT] = s_reg.nar_sync2[`DBGP_TOP_PIN_BIT] & ~s_reg.mclr_en;
    end

    // ------------------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------------------
    assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
    assign s_axi_arready = !s_reg.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_fire = (s_reg.aw_held || aw_hs) && (s_reg.w_held || w_hs);
    assign wr_addr = s_reg.aw_held ? s_reg.aw_addr : s_axi_awaddr[7:0];
    assign wr_data = s_reg.w_held ? s_reg.w_data : s_axi_wdata;
    assign wr_strb = s_reg.w_held ? s_reg.w_strb : s_axi_wstrb;
    assign wr_lane0 = wr_strb[`DBGP_STRB_LANE0];

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // pins pass two flip-flops before any logic sees them
        s_next.wide_sync1 = wide_pin_in;
        s_next.wide_sync2 = s_reg.wide_sync1;
        s_next.nar_sync1 = {input_only_top_pin, narrow_pin_in};
        s_next.nar_sync2 = s_reg.nar_sync1;

        // write address and data may arrive in either order
        if (aw_hs) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr[7:0];
        end
        if (w_hs) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        if (wr_fire) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `DBGP_RESP_OKAY;
            case (wr_addr)
                `DBGP_OFS_WIDE_DATA: begin
                    // unstrobed lane stores the sampled pins back
                    s_next.wide_latch = wr_lane0 ? wr_data[7:0] : wide_rd;
                end
                `DBGP_OFS_WIDE_DIR: begin
                    if (wr_lane0) begin
                        s_next.wide_dir = wr_data[7:0];
                    end
                end
                `DBGP_OFS_NARROW_DATA: begin
                    // top pin has no latch; bits above are dropped
                    s_next.nar_latch = wr_lane0 ? wr_data[2:0] : nar_rd[2:0];
                end
                `DBGP_OFS_NARROW_DIR: begin
                    if (wr_lane0) begin
                        s_next.nar_dir = wr_data[2:0];
                    end
                end
                `DBGP_OFS_ANALOG_SEL: begin
                    if (wr_lane0) begin
                        s_next.analog_sel = wr_data[2:0];
                    end
                end
                `DBGP_OFS_PWM_SEL: begin
                    if (wr_lane0) begin
                        s_next.pwm_sel = wr_data[2:0];
                    end
                end
                `DBGP_OFS_CFG: begin
                    if (wr_lane0) begin
                        s_next.mclr_en = wr_data[`DBGP_MCLR_EN_BIT];
                    end
                end
                default: begin
                    s_next.bresp = `DBGP_RESP_SLVERR;
                end
            endcase
        end

        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (ar_hs) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = `DBGP_RESP_OKAY;
            s_next.rdata = '0;
            case (s_axi_araddr[7:0])
                `DBGP_OFS_WIDE_DATA: begin
                    s_next.rdata[7:0] = wide_rd;
                end
                `DBGP_OFS_WIDE_DIR: begin
                    s_next.rdata[7:0] = s_reg.wide_dir;
                end
                `DBGP_OFS_NARROW_DATA: begin
                    s_next.rdata[3:0] = nar_rd;
                end
                `DBGP_OFS_NARROW_DIR: begin
                    s_next.rdata[2:0] = s_reg.nar_dir;
                    s_next.rdata[`DBGP_TOP_PIN_BIT] = 1'b1;
                end
                `DBGP_OFS_ANALOG_SEL: begin
                    s_next.rdata[2:0] = s_reg.analog_sel;
                end
                `DBGP_OFS_PWM_SEL: begin
                    s_next.rdata[2:0] = s_reg.pwm_sel;
                end
                `DBGP_OFS_CFG: begin
                    s_next.rdata[`DBGP_MCLR_EN_BIT] = s_reg.mclr_en;
                end
                default: begin
                    s_next.rresp = `DBGP_RESP_SLVERR;
                end
            endcase
        end

        // pin drive: low pins from the latch, upper pins may be pwm
        s_next.wide_out[4:0] = s_reg.wide_latch[4:0];
        s_next.wide_out[`DBGP_PWM_B_BIT] = s_reg.pwm_sel[0] ? pwm_channel_b_out
                                                             : s_reg.wide_latch[`DBGP_PWM_B_BIT];
        s_next.wide_out[`DBGP_PWM_C_BIT] = s_reg.pwm_sel[1] ? pwm_channel_c_out
                                                             : s_reg.wide_latch[`DBGP_PWM_C_BIT];
        s_next.wide_out[`DBGP_PWM_D_BIT] = s_reg.pwm_sel[2] ? pwm_channel_d_out
                                                             : s_reg.wide_latch[`DBGP_PWM_D_BIT];
        s_next.nar_out = s_reg.nar_latch;
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.wide_dir <= `DBGP_WIDE_DIR_RST;
            s_reg.nar_dir <= `DBGP_NARROW_DIR_RST;
            s_reg.analog_sel <= `DBGP_ANALOG_SEL_RST;
            s_reg.pwm_sel <= `DBGP_PWM_SEL_RST;
            s_reg.mclr_en <= `DBGP_MCLR_EN_RST;
            // a single reset stands for power-up, where the latch is undefined
            s_reg.wide_latch <= `DBGP_WIDE_LATCH_RST;
            s_reg.nar_latch <= `DBGP_NARROW_LATCH_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign wide_pin_out = s_reg.wide_out;
    assign wide_pin_oe_n = s_reg.wide_dir;
    assign narrow_pin_out = s_reg.nar_out;
    assign narrow_pin_oe_n = s_reg.nar_dir;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_dir_write;
        @(posedge clock) disable iff (rst)
        wr_fire && wr_addr == `DBGP_OFS_WIDE_DIR && wr_lane0
        |=> wide_pin_oe_n == $past(wr_data[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("wide direction write not seen on output enables");

    property p_rmw_keep;
        @(posedge clock) disable iff (rst)
        wr_fire && wr_addr == `DBGP_OFS_WIDE_DATA && !wr_lane0
        |=> s_reg.wide_latch == $past(wide_rd);
    endproperty
    a_rmw_keep: assert property (p_rmw_keep)
        else $error("unstrobed data write did not store sampled pins");

    property p_drive_latch;
        @(posedge clock) disable iff (rst)
        s_reg.pwm_sel == 3'h0 |=> wide_pin_out == $past(s_reg.wide_latch);
    endproperty
    a_drive_latch: assert property (p_drive_latch)
        else $error("pin output does not follow the latch");

    property p_pwm_d;
        @(posedge clock) disable iff (rst)
        s_reg.pwm_sel[2] |=> wide_pin_out[`DBGP_PWM_D_BIT] == $past(pwm_channel_d_out);
    endproperty
    a_pwm_d: assert property (p_pwm_d)
        else $error("pwm channel d does not override the latch");

    property p_pin_read;
        @(posedge clock) disable iff (rst)
        ar_hs && s_axi_araddr[7:0] == `DBGP_OFS_WIDE_DATA
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(wide_pin_in, 3);
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("wide data read does not return pin levels");

    property p_analog_zero;
        @(posedge clock) disable iff (rst)
        ar_hs && s_axi_araddr[7:0] == `DBGP_OFS_NARROW_DATA
        |=> (s_axi_rdata[2:0] & $past(s_reg.analog_sel)) == 3'h0;
    endproperty
    a_analog_zero: assert property (p_analog_zero)
        else $error("analog pin read back non-zero");

    property p_top_dir;
        @(posedge clock) disable iff (rst)
        ar_hs && s_axi_araddr[7:0] == `DBGP_OFS_NARROW_DIR
        |=> s_axi_rdata[`DBGP_TOP_PIN_BIT] && s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_top_dir: assert property (p_top_dir)
        else $error("input-only direction bit not read as one");

    property p_mclr_zero;
        @(posedge clock) disable iff (rst)
        ar_hs && s_axi_araddr[7:0] == `DBGP_OFS_NARROW_DATA && s_reg.mclr_en
        |=> !s_axi_rdata[`DBGP_TOP_PIN_BIT];
    endproperty
    a_mclr_zero: assert property (p_mclr_zero)
        else $error("top pin reads non-zero with master clear enabled");

    property p_dir_reset;
        @(posedge clock) disable iff (rst)
        $past(rst) |-> wide_pin_oe_n == `DBGP_WIDE_DIR_RST;
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("wide direction not all ones after reset");

    property p_unimpl_zero;
        @(posedge clock) disable iff (rst)
        ar_hs && s_axi_araddr[7:0] == `DBGP_OFS_NARROW_DATA
        |=> s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented narrow data bits read non-zero");

    property p_write_resp;
        @(posedge clock) disable iff (rst)
        wr_fire |=> s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write response not raised one cycle after write");

    property p_bvalid_clear;
        @(posedge clock) disable iff (rst)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bvalid_clear: assert property (p_bvalid_clear)
        else $error("write response not cleared after it was taken");

    property p_narrow_dir;
        @(posedge clock) disable iff (rst)
        wr_fire && wr_addr == `DBGP_OFS_NARROW_DIR && wr_lane0
        |=> narrow_pin_oe_n == $past(wr_data[2:0]);
    endproperty
    a_narrow_dir: assert property (p_narrow_dir)
        else $error("narrow direction write not seen on output enables");

endmodule

`default_nettype wire

// ===== hw/dbgp_defines.svh
// register offsets, reset values and field positions of the dual gpio ports
`ifndef DBGP_DEFINES_SVH
`define DBGP_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define DBGP_OFS_WIDE_DATA 8'h00
`define DBGP_OFS_WIDE_DIR 8'h04
`define DBGP_OFS_NARROW_DATA 8'h08
`define DBGP_OFS_NARROW_DIR 8'h0C
`define DBGP_OFS_ANALOG_SEL 8'h10
`define DBGP_OFS_PWM_SEL 8'h14
`define DBGP_OFS_CFG 8'h18

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DBGP_WIDE_DIR_RST 8'hFF
`define DBGP_NARROW_DIR_RST 3'h7
`define DBGP_ANALOG_SEL_RST 3'h7
`define DBGP_PWM_SEL_RST 3'h0
`define DBGP_MCLR_EN_RST 1'h1
`define DBGP_WIDE_LATCH_RST 8'h00
`define DBGP_NARROW_LATCH_RST 3'h0

// ----------------------------------------------------------------------------
// field positions and bus codes
// ----------------------------------------------------------------------------
`define DBGP_TOP_PIN_BIT 3
`define DBGP_PWM_B_BIT 5
`define DBGP_PWM_C_BIT 6
`define DBGP_PWM_D_BIT 7
`define DBGP_MCLR_EN_BIT 0
`define DBGP_STRB_LANE0 0
`define DBGP_RESP_OKAY 2'h0
`define DBGP_RESP_SLVERR 2'h2

`endif

// ===== hw/dbgp_pkg.sv
// types shared by the dual gpio port design
package dbgp_pkg;

    // ------------------------------------------------------------------------
    // complete register state of the port block
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] wide_sync1;
        logic [7:0] wide_sync2;
        logic [3:0] nar_sync1;
        logic [3:0] nar_sync2;
        logic [7:0] wide_latch;
        logic [7:0] wide_dir;
        logic [2:0] nar_latch;
        logic [2:0] nar_dir;
        logic [2:0] analog_sel;
        logic [2:0] pwm_sel;
        logic mclr_en;
        logic [7:0] wide_out;
        logic [2:0] nar_out;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dbgp_state_s;

endpackage

// ===== dv/dbgp_board_model.sv
// board-side model of the port pins: resolves each bidirectional pin from the device driver and the board level
`timescale 1ns/1ps
`default_nettype none

module dbgp_board_model (
    input wire logic [7:0] dev_wide,
    input wire logic [7:0] dev_wide_oe_n,
    input wire logic [2:0] dev_nar,
    input wire logic [2:0] dev_nar_oe_n,
    input wire logic [7:0] board_wide,
    input wire logic [2:0] board_nar,
    output logic [7:0] pin_wide,
    output logic [2:0] pin_nar
);
    // ------------------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------------------
    // a released pin shows the board level, a driven pin shows the device level
    assign pin_wide = (dev_wide_oe_n & board_wide) | (~dev_wide_oe_n & dev_wide);
    assign pin_nar = (dev_nar_oe_n & board_nar) | (~dev_nar_oe_n & dev_nar);
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench of the dual gpio ports driven over axi4-lite
`include "dbgp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module tb_top;
    logic clock, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, top_pin, pwm_b, pwm_c, pwm_d;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] wide_in, wide_out, wide_oe_n, board_wide;
    logic [2:0] nar_in, nar_out, nar_oe_n, board_nar;
    logic [2:0] sel_t [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    logic [7:0] exp_t [5] = '{8'h5A, 8'h7A, 8'h1A, 8'hDA, 8'hBA};
    int error_cnt, samples_checked;

    dbgp_top u_dut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wide_pin_in(wide_in),
        .wide_pin_out(wide_out), .wide_pin_oe_n(wide_oe_n), .narrow_pin_in(nar_in),
        .input_only_top_pin(top_pin), .narrow_pin_out(nar_out), .narrow_pin_oe_n(nar_oe_n),
        .pwm_channel_b_out(pwm_b), .pwm_channel_c_out(pwm_c), .pwm_channel_d_out(pwm_d));

    dbgp_board_model u_board (.dev_wide(wide_out), .dev_wide_oe_n(wide_oe_n), .dev_nar(nar_out),
        .dev_nar_oe_n(nar_oe_n), .board_wide(board_wide), .board_nar(board_nar),
        .pin_wide(wide_in), .pin_nar(nar_in));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ------------------------------------------------------------------------
    // closing report and bus tasks
    // ------------------------------------------------------------------------
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_out();
        error_cnt++;
        $display("wrong value at %0t: bus answer never came", $time);
        end_sim();
    endtask

    // ready is sampled at the falling edge, so the handshake edge that follows is known in advance
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        logic aw_ok, w_ok, b_ok;
        logic [1:0] r;
        @(posedge clock);
        awaddr <= {24'h0, a};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_ok = 1'b0;
        for (n = 0; n < 100 && !b_ok; n++) begin
            @(negedge clock);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            r = bresp;
            @(posedge clock);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) bready <= 1'b0;
        end
        if (!b_ok) wait_out();
        `CHK(r, er)
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ar_ok, r_ok;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clock);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_ok = 1'b0;
        for (n = 0; n < 100 && !r_ok; n++) begin
            @(negedge clock);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) rready <= 1'b0;
        end
        if (!r_ok) wait_out();
        `CHK(d, ed)
        `CHK(r, er)
    endtask

    // pin changes need two edges through the synchroniser before a read sees them
    task automatic settle();
        repeat (4) @(posedge clock);
        // end off the edge so registered outputs are compared once settled
        @(negedge clock);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, pwm_b, pwm_c, pwm_d} = 8'h00;
        {awaddr, wdata, araddr, wstrb} = 100'h0;
        board_wide = 8'hA5;
        board_nar = 3'h5;
        top_pin = 1'b1;
        error_cnt = 0;
        samples_checked = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        settle();
        rdchk(`DBGP_OFS_WIDE_DIR, 32'hFF, `DBGP_RESP_OKAY);
        rdchk(`DBGP_OFS_NARROW_DIR, 32'hF, `DBGP_RESP_OKAY);
        `CHK(wide_oe_n, 8'hFF)
        `CHK(nar_oe_n, 3'h7)
        wr(`DBGP_OFS_WIDE_DATA, 32'h3C, 4'h1, `DBGP_RESP_OKAY);
        settle();
        rdchk(`DBGP_OFS_WIDE_DATA, 32'hA5, `DBGP_RESP_OKAY);
        wr(`DBGP_OFS_WIDE_DIR, 32'h00, 4'h1, `DBGP_RESP_OKAY);
        settle();
        `CHK(wide_oe_n, 8'h00)
        `CHK(wide_out, 8'h3C)
        rdchk(`DBGP_OFS_WIDE_DATA, 32'h3C, `DBGP_RESP_OKAY);
        // unstrobed write stores the sampled pins, not the old latch
        wr(`DBGP_OFS_WIDE_DIR, 32'hFF, 4'h1, `DBGP_RESP_OKAY);
        board_wide <= 8'h5A;
        settle();
        wr(`DBGP_OFS_WIDE_DATA, 32'h00, 4'h0, `DBGP_RESP_OKAY);
        board_wide <= 8'hFF;
        wr(`DBGP_OFS_WIDE_DIR, 32'h00, 4'h1, `DBGP_RESP_OKAY);
        settle();
        rdchk(`DBGP_OFS_WIDE_DATA, 32'h5A, `DBGP_RESP_OKAY);
        pwm_b <= 1'b1;
        pwm_d <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(`DBGP_OFS_PWM_SEL, {29'h0, sel_t[i]}, 4'h1, `DBGP_RESP_OKAY);
            settle();
            `CHK(wide_out, exp_t[i])
        end
        rdchk(`DBGP_OFS_NARROW_DATA, 32'h0, `DBGP_RESP_OKAY);
        wr(`DBGP_OFS_ANALOG_SEL, 32'h0, 4'h1, `DBGP_RESP_OKAY);
        settle();
        rdchk(`DBGP_OFS_NARROW_DATA, 32'h5, `DBGP_RESP_OKAY);
        wr(`DBGP_OFS_CFG, 32'h0, 4'h1, `DBGP_RESP_OKAY);
        settle();
        rdchk(`DBGP_OFS_NARROW_DATA, 32'hD, `DBGP_RESP_OKAY);
        wr(`DBGP_OFS_NARROW_DIR, 32'h0, 4'h1, `DBGP_RESP_OKAY);
        wr(`DBGP_OFS_NARROW_DATA, 32'hF2, 4'h1, `DBGP_RESP_OKAY);
        settle();
        `CHK(nar_oe_n, 3'h0)
        `CHK(nar_out, 3'h2)
        rdchk(`DBGP_OFS_NARROW_DIR, 32'h8, `DBGP_RESP_OKAY);
        rdchk(`DBGP_OFS_NARROW_DATA, 32'hA, `DBGP_RESP_OKAY);
        rdchk(8'h1C, 32'h0, `DBGP_RESP_SLVERR);
        wr(8'h1C, 32'hFF, 4'h1, `DBGP_RESP_SLVERR);
        rst <= 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        settle();
        `CHK(wide_oe_n, 8'hFF)
        rdchk(`DBGP_OFS_WIDE_DIR, 32'hFF, `DBGP_RESP_OKAY);
        end_sim();
    end
endmodule

`default_nettype wire
